// *** design/parser_pkg.sv ***
package parser_pkg;

  // Character codes
  localparam logic [7:0] char_lf        = 8'h0a;
  localparam logic [7:0] char_cr        = 8'h0d;
  localparam logic [7:0] char_space     = 8'h20;
  localparam logic [7:0] char_ws_hi     = 8'h09;
  localparam logic [7:0] char_ws_lo2    = 8'h0b;
  localparam logic [7:0] char_semicolon = 8'h3b;
  localparam logic [7:0] char_colon     = 8'h3a;
  localparam logic [7:0] char_star      = 8'h2a;
  localparam logic [7:0] char_query     = 8'h3f;
  localparam logic [7:0] char_lower_a   = 8'h61;
  localparam logic [7:0] char_lower_z   = 8'h7a;
  localparam logic [7:0] char_upper_a   = 8'h41;
  localparam logic [7:0] char_upper_z   = 8'h5a;
  localparam logic [7:0] char_digit_0   = 8'h30;
  localparam logic [7:0] char_digit_9   = 8'h39;
  localparam logic [7:0] case_bit       = 8'h20;

  // Selector index limits
  localparam logic [3:0] index_min      = 4'h1;
  localparam logic [3:0] channel_max    = 4'h4;
  localparam logic [3:0] slot_max       = 4'h4;
  localparam logic [3:0] cursor_max     = 4'h2;
  localparam logic [3:0] stored_max     = 4'h4;

  // Mnemonic table geometry
  localparam int name_len    = 8;
  localparam int path_depth  = 4;
  localparam int table_size  = 8;
  localparam int index_none  = 0;

  // Selector kinds attached to a table entry
  typedef enum logic [2:0]
  {
    sel_none    = 3'b000,
    sel_channel = 3'b001,
    sel_slot    = 3'b010,
    sel_cursor  = 3'b011,
    sel_stored  = 3'b100,
    sel_trace   = 3'b101
  } selector_type;

  // Serial terminator choice for output
  typedef enum logic [1:0]
  {
    term_cr   = 2'b00,
    term_lf   = 2'b01,
    term_crlf = 2'b10,
    term_lfcr = 2'b11
  } terminator_type;

  // Received byte with its end indication
  typedef struct packed
  {
    logic [7:0] data;
    logic       end_flag;
  } rx_byte_type;

  // Resolved command handed to the executer
  typedef struct packed
  {
    logic [2:0]  level;
    logic [15:0] path;
    logic [3:0]  index;
    logic        is_query;
    logic        is_star;
  } command_type;

  // Response byte with its end indication
  typedef struct packed
  {
    logic [7:0] data;
    logic       end_flag;
  } tx_byte_type;

endpackage : parser_pkg

// *** design/remote_command_message_parser.sv ***
`timescale 1ns/100ps
module remote_command_message_parser
  import parser_pkg::*;
#(
  parameter int mnem_count = table_size
)
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset_n,
  // Incoming byte stream from the link
  input  wire rx_byte_type  rx_byte,
  input  wire logic         rx_valid,
  input  wire logic         serial_link,
  input  wire logic         device_clear,
  // Mode settings
  input  wire logic         header_echo,
  input  wire logic         full_length_label_select,
  input  wire terminator_type out_terminator,
  // Mnemonic table: full spelling, minimum length, level and selector kind
  input  wire logic [mnem_count*name_len*8-1:0] mnem_text,
  input  wire logic [mnem_count*4-1:0]          mnem_min,
  input  wire logic [mnem_count*3-1:0]          mnem_level,
  input  wire logic [mnem_count*3-1:0]          mnem_selector,
  // Resolved commands out
  output command_type       command,
  output logic              command_valid,
  input  wire logic         command_ready,
  output logic              command_error,
  output logic              message_done,
  // Response bytes from the executer and out to the link
  input  wire logic [7:0]   resp_data,
  input  wire logic         resp_valid,
  input  wire logic         resp_last,
  output tx_byte_type       tx_byte,
  output logic              tx_valid
);

  typedef enum logic [2:0]
  {
    st_skip   = 3'b000,
    st_name   = 3'b001,
    st_index  = 3'b010,
    st_rest   = 3'b011,
    st_issue  = 3'b100,
    st_flush  = 3'b101
  } state_type;

  state_type                 state_reg, state_next;
  logic [name_len*8-1:0]     word_reg, word_next;
  logic [3:0]                wlen_reg, wlen_next;
  logic [3:0]                index_reg, index_next;
  logic [15:0]               path_reg, path_next, cur_reg, cur_next;
  logic [2:0]                level_reg, level_next, lvl_reg, lvl_next;
  logic                      rooted_reg, rooted_next, star_reg, star_next;
  logic                      query_reg, query_next, ended_reg, ended_next;
  logic                      err_reg, err_next, done_reg, done_next;
  logic                      sep_reg, sep_next, pend_reg, pend_next;
  logic                      last_cr_reg, last_cr_next;
  command_type               cmd_reg, cmd_next;

  // Byte classification with case folding
  logic [7:0] ch, up;
  logic       is_ws, is_term, is_alpha, is_digit, is_sep, end_now;
  always_comb
  begin
    ch       = rx_byte.data;
    up       = (ch >= char_lower_a && ch <= char_lower_z) ? (ch & ~case_bit) : ch;
    is_ws    = (ch <= char_ws_hi) || (ch >= char_ws_lo2 && ch <= char_space);
    is_alpha = (up >= char_upper_a && up <= char_upper_z);
    is_digit = (ch >= char_digit_0 && ch <= char_digit_9);
    is_term  = (ch == char_lf) || (serial_link && ch == char_cr);
    is_sep   = (ch == char_semicolon);
    end_now  = is_term || (!serial_link && rx_byte.end_flag);
  end

  // Each resolved level owns one nibble of the path code; entries past 15 would alias
  localparam int          code_bits = 4;
  localparam logic [15:0] code_mask = 16'h000f;

  // Mnemonic lookup: full spelling or any prefix at least the minimum length
  logic       hit;
  logic [2:0] hit_sel;
  logic [15:0] hit_code;
  always_comb
  begin
    hit      = 1'b0;
    hit_sel  = sel_none;
    hit_code = 16'h0000;
    for (int i = 0; i < mnem_count; i++)
    begin
      if (mnem_level[i*3 +: 3] == lvl_reg && wlen_reg >= mnem_min[i*4 +: 4]
          && (mnem_text[i*name_len*8 +: name_len*8] >> ((name_len - wlen_reg) * 8))
             == (word_reg >> ((name_len - wlen_reg) * 8)) && !hit)
      begin
        hit      = 1'b1;
        hit_sel  = mnem_selector[i*3 +: 3];
        hit_code = 16'(i + 1);
      end
    end
  end

  // Index range check per selector kind
  logic idx_ok;
  always_comb
  begin
    case (selector_type'(hit_sel))
      sel_channel: idx_ok = index_reg >= index_min && index_reg <= channel_max;
      sel_slot:    idx_ok = index_reg >= index_min && index_reg <= slot_max;
      sel_cursor:  idx_ok = index_reg >= index_min && index_reg <= cursor_max;
      sel_stored:  idx_ok = index_reg >= index_min && index_reg <= stored_max;
      sel_trace:   idx_ok = index_reg == 4'(index_none) || index_reg <= channel_max;
      default:     idx_ok = index_reg == 4'(index_none);
    endcase
  end

  // Parser next state; one byte per cycle, stalls while a command waits
  logic take;
  assign take = rx_valid && state_reg != st_issue;
  always_comb
  begin
    state_next = state_reg;    word_next = word_reg;    wlen_next = wlen_reg;
    index_next = index_reg;    path_next = path_reg;    cur_next = cur_reg;
    level_next = level_reg;    lvl_next = lvl_reg;      rooted_next = rooted_reg;
    star_next = star_reg;      query_next = query_reg;  ended_next = ended_reg;
    err_next = 1'b0;           done_next = 1'b0;        sep_next = sep_reg;
    pend_next = pend_reg;      last_cr_next = last_cr_reg; cmd_next = cmd_reg;
    if (take)
      last_cr_next = (ch == char_cr) || (ch == char_lf);
    case (state_reg)
      st_skip:
        if (take)
        begin
          if (serial_link && last_cr_reg && (ch == char_lf || ch == char_cr))
            last_cr_next = 1'b0;
          else if (end_now)
          begin
            done_next = 1'b1;
            level_next = 3'd0;
            path_next = 16'h0000;
          end
          else if (is_ws || is_sep)
            ;
          else if (ch == char_colon && !rooted_reg)
            rooted_next = 1'b1;
          else if (ch == char_star && !rooted_reg)
          begin
            star_next = 1'b1;
            state_next = st_name;
          end
          else if (is_alpha)
          begin
            word_next = {up, {(name_len-1)*8{1'b0}}};
            wlen_next = 4'd1;
            // Rooted restarts at level 0, else replace the last mnemonic
            lvl_next = rooted_reg ? 3'd0 : (level_reg == 3'd0 ? 3'd0 : level_reg - 3'd1);
            cur_next = (rooted_reg || level_reg == 3'd0) ? 16'h0000
                       : path_reg & ~(code_mask << (code_bits * (int'(level_reg) - 1)));
            state_next = st_name;
          end
          else
            state_next = st_flush;
        end
      st_name, st_index:
        if (take)
        begin
          if (is_alpha && state_reg == st_name && wlen_reg < 4'(name_len))
          begin
            word_next[(name_len-1-int'(wlen_reg))*8 +: 8] = up;
            wlen_next = wlen_reg + 4'd1;
          end
          else if (is_digit)
          begin
            index_next = 4'(ch - char_digit_0);
            state_next = st_index;
          end
          else if (!star_reg && (ch == char_colon || ch == char_query || is_ws || is_sep || end_now))
          begin
            if (!hit || !idx_ok || lvl_reg >= 3'(path_depth))
              state_next = (is_sep || end_now) ? st_skip : st_flush;
            else
            begin
              cur_next = cur_reg | (hit_code << (code_bits * int'(lvl_reg)));
              lvl_next = lvl_reg + 3'd1;
              word_next = '0;
              wlen_next = 4'd0;
              if (ch == char_colon)
                state_next = st_name;
              else
              begin
                query_next = (ch == char_query);
                state_next = st_rest;
              end
            end
            err_next = !hit || !idx_ok;
            if (!hit || !idx_ok)
            begin
              rooted_next = 1'b0;
              done_next = end_now;
            end
            sep_next = is_sep;
            ended_next = end_now;
          end
          else if (star_reg && (is_ws || is_sep || end_now || ch == char_query))
          begin
            query_next = (ch == char_query);
            sep_next = is_sep;
            ended_next = end_now;
            state_next = (is_sep || end_now) ? st_issue : st_rest;
          end
        end
      st_rest:
        if (take && (is_sep || end_now))
        begin
          sep_next = is_sep;
          ended_next = end_now;
          state_next = st_issue;
        end
      st_issue:
      begin
        cmd_next = '{level: lvl_reg, path: star_reg ? 16'h0000 : cur_reg,
                     index: index_reg, is_query: query_reg, is_star: star_reg};
        if (command_ready)
        begin
          if (!star_reg)
          begin
            path_next = cur_reg;
            level_next = lvl_reg;
          end
          done_next = ended_reg;
          if (ended_reg)
          begin
            path_next = 16'h0000;
            level_next = 3'd0;
          end
          star_next = 1'b0;        rooted_next = 1'b0;      index_next = 4'd0;
          query_next = 1'b0;       word_next = '0;          wlen_next = 4'd0;
          state_next = st_skip;
        end
      end
      st_flush:
        if (take && (is_sep || end_now))
        begin
          done_next = end_now;
          rooted_next = 1'b0;      star_next = 1'b0;        index_next = 4'd0;
          state_next = st_skip;
        end
      default:
        state_next = st_skip;
    endcase
    if (state_next == st_skip && state_reg != st_skip && state_reg != st_issue)
    begin
      word_next = '0;
      wlen_next = 4'd0;
      index_next = 4'd0;
    end
  end

  // Parser registers; device clear returns to a clean start
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= st_skip;    word_reg <= '0;   wlen_reg <= 4'd0;   index_reg <= 4'd0;
      path_reg <= 16'h0000;    cur_reg <= 16'h0000;  level_reg <= 3'd0;  lvl_reg <= 3'd0;
      rooted_reg <= 1'b0;      star_reg <= 1'b0;  query_reg <= 1'b0;  ended_reg <= 1'b0;
      err_reg <= 1'b0;         done_reg <= 1'b0;  sep_reg <= 1'b0;    pend_reg <= 1'b0;
      last_cr_reg <= 1'b0;     cmd_reg <= '0;
    end
    else if (device_clear)
    begin
      state_reg <= st_skip;    word_reg <= '0;   wlen_reg <= 4'd0;   index_reg <= 4'd0;
      path_reg <= 16'h0000;    cur_reg <= 16'h0000;  level_reg <= 3'd0;  lvl_reg <= 3'd0;
      rooted_reg <= 1'b0;      star_reg <= 1'b0;  query_reg <= 1'b0;  ended_reg <= 1'b0;
      err_reg <= 1'b0;         done_reg <= 1'b0;  sep_reg <= 1'b0;    pend_reg <= 1'b0;
      last_cr_reg <= 1'b0;     cmd_reg <= '0;
    end
    else
    begin
      state_reg <= state_next; word_reg <= word_next; wlen_reg <= wlen_next;
      index_reg <= index_next; path_reg <= path_next; cur_reg <= cur_next;
      level_reg <= level_next; lvl_reg <= lvl_next;   rooted_reg <= rooted_next;
      star_reg <= star_next;   query_reg <= query_next; ended_reg <= ended_next;
      err_reg <= err_next;     done_reg <= done_next; sep_reg <= sep_next;
      pend_reg <= pend_next;   last_cr_reg <= last_cr_next; cmd_reg <= cmd_next;
    end
  end

  assign command       = cmd_next;
  assign command_valid = (state_reg == st_issue);
  assign command_error = err_reg;
  assign message_done  = done_reg;

  // Response joiner: the executer supplies headers per the echo and
  // full length settings; this stage upper-cases, inserts semicolons
  // between parts and closes with line feed plus end indication
  typedef enum logic [1:0]
  {
    tx_idle = 2'b00,
    tx_part = 2'b01,
    tx_term = 2'b10
  } tx_state_type;

  tx_state_type tx_state_reg, tx_state_next;
  tx_byte_type  tx_reg, tx_next;
  logic         txv_reg, txv_next, more_reg, more_next;
  logic [7:0]   rup;
  logic         echo_long;

  always_comb
  begin
    rup = (resp_data >= char_lower_a && resp_data <= char_lower_z)
          ? (resp_data & ~case_bit) : resp_data;
    echo_long = header_echo && full_length_label_select;
    tx_state_next = tx_state_reg;
    tx_next = tx_reg;
    txv_next = 1'b0;
    more_next = more_reg;
    case (tx_state_reg)
      tx_idle, tx_part:
        if (resp_valid)
        begin
          tx_next = '{data: (more_reg && tx_state_reg == tx_idle) ? char_semicolon : rup,
                      end_flag: 1'b0};
          txv_next = 1'b1;
          if (!(more_reg && tx_state_reg == tx_idle))
            tx_state_next = resp_last ? tx_idle : tx_part;
          if (resp_last && !(more_reg && tx_state_reg == tx_idle))
            more_next = 1'b1;
          if (more_reg && tx_state_reg == tx_idle)
            tx_state_next = tx_part;
        end
        else if (message_done && more_reg && tx_state_reg == tx_idle)
          tx_state_next = tx_term;
      tx_term:
      begin
        tx_next = '{data: char_lf, end_flag: 1'b1};
        txv_next = 1'b1;
        more_next = 1'b0;
        tx_state_next = tx_idle;
      end
      default:
        tx_state_next = tx_idle;
    endcase
  end

  // Response registers; the semicolon byte is emitted before the stalled
  // part byte, so the executer must hold resp_valid until it is taken
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_state_reg <= tx_idle;
      tx_reg <= '0;
      txv_reg <= 1'b0;
      more_reg <= 1'b0;
    end
    else if (device_clear)
    begin
      tx_state_reg <= tx_idle;
      tx_reg <= '0;
      txv_reg <= 1'b0;
      more_reg <= 1'b0;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_reg <= tx_next;
      txv_reg <= txv_next;
      more_reg <= more_next;
    end
  end

  assign tx_byte  = tx_reg;
  assign tx_valid = txv_reg;

  // Command resolution, device clear and response checks
  a_star_keeps_path: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg == st_issue && star_reg && command_ready && !ended_reg && !device_clear)
    |=> path_reg == $past(path_reg))
    else $error("Star command changed saved path");
  a_clear_idles: assert property (@(posedge clock) disable iff (!reset_n)
    device_clear |=> state_reg == st_skip && !txv_reg && !more_reg)
    else $error("Device clear did not reset parser");
  a_final_byte_lf: assert property (@(posedge clock) disable iff (!reset_n)
    (tx_valid && tx_byte.end_flag) |-> tx_byte.data == char_lf)
    else $error("End indication without line feed");
  a_resp_upper: assert property (@(posedge clock) disable iff (!reset_n)
    tx_valid |-> !(tx_byte.data >= char_lower_a && tx_byte.data <= char_lower_z))
    else $error("Lower case letter in response");
  a_blank_no_cmd: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg == st_skip && take && (is_ws || ch == char_lf))
    |=> state_reg == st_skip && !command_valid && !command_error)
    else $error("Blank unit produced a command");
  a_unknown_err: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg == st_name && take && !star_reg && !hit && (is_sep || end_now)
     && !device_clear) |=> command_error && state_reg == st_skip)
    else $error("Unknown header not flagged");
  a_gpib_end: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg == st_skip && take && !serial_link && rx_byte.end_flag && !device_clear)
    |=> message_done)
    else $error("End indication did not finish message");
  a_cursor_range: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg == st_index && take && !star_reg && hit_sel == sel_cursor
     && index_reg > cursor_max && ch == char_query && !device_clear) |=> command_error)
    else $error("Cursor index above two accepted");

endmodule : remote_command_message_parser

// *** testbench/host_model.sv ***
`timescale 1ns/100ps
module host_model
  import parser_pkg::*;
(
  // Clock and parser stall
  input  wire logic  clock,
  input  wire logic  command_valid,
  // Byte stream to the parser
  output rx_byte_type rx_byte,
  output logic        rx_valid
);
  initial
  begin
    rx_byte  = '0;
    rx_valid = 1'b0;
  end

  // Offer one byte; while the parser stalls the byte is held unchanged
  task automatic put(input logic [7:0] b, input logic e);
    logic hold;
    rx_byte  = '{data: b, end_flag: e};
    rx_valid = 1'b1;
    do
    begin
      hold = command_valid;
      @(negedge clock);
    end
    while (hold === 1'b1);
  endtask : put

  // Whole message; end flag only on the last byte when asked for
  task automatic send(input string s, input logic eoi);
    for (int i = 0; i < s.len(); i++)
      put(s[i], eoi && (i == s.len() - 1));
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte; // Released line must not look like the last byte
    @(negedge clock);
  endtask : send
endmodule : host_model

// *** testbench/tb_remote_command_message_parser.sv ***
`timescale 1ns/100ps
module tb_remote_command_message_parser
  import parser_pkg::*;
;
  logic        clock, reset_n, device_clear, header_echo, full_length_label_select;
  logic        serial_link, command_ready, command_valid, command_error, message_done;
  logic        rx_valid, resp_valid, resp_last, tx_valid;
  logic [7:0]  resp_data;
  rx_byte_type rx_byte;
  tx_byte_type tx_byte;
  command_type command;
  terminator_type out_terminator;
  logic [table_size*name_len*8-1:0] mnem_text;
  logic [table_size*4-1:0]          mnem_min;
  logic [table_size*3-1:0]          mnem_level, mnem_selector;
  command_type cq[$];
  tx_byte_type tq[$];
  int          errs, dones, cycles, mismatches, compares;

  host_model u_host (.clock(clock), .command_valid(command_valid), .rx_byte(rx_byte),
                     .rx_valid(rx_valid));

  remote_command_message_parser u_dut (.clock(clock), .reset_n(reset_n), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .serial_link(serial_link), .device_clear(device_clear),
    .header_echo(header_echo), .full_length_label_select(full_length_label_select),
    .out_terminator(out_terminator), .mnem_text(mnem_text), .mnem_min(mnem_min),
    .mnem_level(mnem_level), .mnem_selector(mnem_selector), .command(command),
    .command_valid(command_valid), .command_ready(command_ready),
    .command_error(command_error), .message_done(message_done), .resp_data(resp_data),
    .resp_valid(resp_valid), .resp_last(resp_last), .tx_byte(tx_byte), .tx_valid(tx_valid));

  always #5 clock = ~clock;

  // Collect what the parser hands out; the ceiling cuts a hang short
  always @(posedge clock)
  begin
    if (command_valid === 1'b1 && command_ready === 1'b1)
      cq.push_back(command);
    if (command_error === 1'b1)
      errs++;
    if (message_done === 1'b1)
      dones++;
    if (tx_valid === 1'b1)
      tq.push_back(tx_byte);
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // Table entry; names are stored left aligned, zero padded
  task automatic ent(input int i, input logic [63:0] nm, input int n, input logic [3:0] mn,
                     input logic [2:0] lv, input selector_type sl);
    mnem_text[i*64 +: 64] = nm << (8 * (8 - n));
    mnem_min[i*4 +: 4]    = mn;
    mnem_level[i*3 +: 3]  = lv;
    mnem_selector[i*3 +: 3] = sl;
  endtask : ent

  task automatic run(input string s, input logic eoi);
    @(negedge clock);
    cq.delete();
    tq.delete();
    errs  = 0;
    dones = 0;
    u_host.send(s, eoi);
    repeat (6) @(negedge clock);
  endtask : run

  task automatic wait_cv();
    for (int i = 0; i < 60 && command_valid !== 1'b1; i++)
      @(negedge clock);
  endtask : wait_cv

  task automatic resp(input logic [7:0] d, input logic last, input int n);
    resp_data  = d;
    resp_valid = 1'b1;
    resp_last  = last;
    repeat (n) @(negedge clock);
  endtask : resp

  task automatic accept();
    command_ready = 1'b1;
    @(negedge clock);
    command_ready = 1'b0;
  endtask : accept

  task automatic one_msg();
    check("commands", cq.size(), 1);
    check("done pulses", dones, 1);
    check("errors", errs, 0);
  endtask : one_msg

  task automatic t_case();
    run("\001\013 acq:mod 1;:ACQUIRE:MODE 2\n", 1'b0);
    check("case fold count", cq.size(), 2);
    check("case fold", cq[0], cq[1]);
    check("case errors", errs, 0);
  endtask : t_case

  task automatic t_path();
    run("ACQ:MODE 1;NUMAVG 8;*TRG;NUMAV 2;:ACQ:NUMAVG?\n", 1'b0);
    check("chain count", cq.size(), 5);
    check("path moved", cq[0].path == cq[1].path, 0);
    check("star flag", cq[2].is_star, 1);
    check("after star", cq[3], cq[1]);
    check("root restart", cq[4].path, cq[1].path);
    check("query order", {cq[0].is_query, cq[4].is_query}, 2'b01);
    run("ACQ:MODE 1;:NUMAVG 2;:ACQ:MODE 3\n", 1'b0);
    check("extra colon error", errs, 1);
    check("resume count", cq.size(), 2);
    run("XYZ;ACQ?\n", 1'b0);
    check("unknown error", errs, 1);
    check("after unknown", cq.size(), 1);
    run("  \n \n", 1'b0);
    check("blank count", cq.size() + errs, 0);
  endtask : t_path

  task automatic t_term();
    string tm [4] = '{"\r", "\n", "\r\n", "\n\r"};
    run("ACQ:MODE 1", 1'b1);
    one_msg();
    run("ACQ:MODE 1\r\n", 1'b1);
    one_msg();
    run("ACQ:MODE 1; ", 1'b1);
    one_msg();
    serial_link = 1'b1;
    foreach (tm[i])
    begin
      out_terminator = terminator_type'(i);
      run({"ACQ:MODE 1", tm[i]}, 1'b0);
      one_msg();
    end
    serial_link = 1'b0;
  endtask : t_term

  task automatic t_sel();
    string s [10] = '{"CH1?", "CH4?", "CH5?", "MEAS1?", "MEAS4?", "MEAS0?", "POSITION2?",
                      "POSITION3?", "REF4?", "MATH?"};
    int    ix [10] = '{1, 4, -1, 1, 4, -1, 2, -1, 4, index_none};
    for (int i = 0; i < 10; i++)
    begin
      run({s[i], "\n"}, 1'b0);
      check("selector error", errs, ix[i] < 0);
      if (ix[i] >= 0)
        check("selector index", cq[0].index, 4'(ix[i]));
    end
  endtask : t_sel

  task automatic t_resp();
    string ex = "AB;C\n";
    header_echo = 1'b1;
    full_length_label_select = 1'b1;
    fork
      run("ACQ?;CH2?\n", 1'b0);
    join_none
    wait_cv();
    resp(8'h61, 1'b0, 1);
    resp(8'h62, 1'b1, 1);
    resp_valid = 1'b0;
    accept();
    wait_cv();
    resp(8'h63, 1'b1, 2); // Joiner spends the first cycle on the separator
    resp_valid = 1'b0;
    accept();
    wait fork;
    check("reply length", tq.size(), 5);
    for (int i = 0; i < 5 && i < tq.size(); i++)
      check("reply byte", tq[i], {ex[i], (i == 4)});
  endtask : t_resp

  task automatic t_clear();
    fork
      run("ACQ?;ACQ?\n", 1'b0);
    join_none
    wait_cv();
    resp(8'h61, 1'b1, 1);
    resp_valid   = 1'b0;
    device_clear = 1'b1;
    @(negedge clock);
    device_clear = 1'b0;
    @(negedge clock);
    check("valid after clear", command_valid, 0);
    command_ready = 1'b1;
    wait fork;
    check("queue emptied", tq.size(), 1);
    check("command after clear", cq.size(), 1);
  endtask : t_clear

  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    {device_clear, header_echo, full_length_label_select, serial_link} = '0;
    {resp_valid, resp_last, command_ready} = 3'b001;
    resp_data = 8'h00;
    out_terminator = term_lf;
    ent(0, "ACQUIRE", 7, 4'h3, 3'h0, sel_none);
    ent(1, "MODE", 4, 4'h3, 3'h1, sel_none);
    ent(2, "NUMAVG", 6, 4'h5, 3'h1, sel_none);
    ent(3, "CH", 2, 4'h2, 3'h0, sel_channel);
    ent(4, "MEAS", 4, 4'h4, 3'h0, sel_slot);
    ent(5, "POSITION", 8, 4'h8, 3'h0, sel_cursor);
    ent(6, "REF", 3, 4'h3, 3'h0, sel_stored);
    ent(7, "MATH", 4, 4'h4, 3'h0, sel_trace);
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    t_case();
    t_path();
    t_term();
    t_sel();
    command_ready = 1'b0;
    t_resp();
    t_clear();
    final_report();
  end
endmodule : tb_remote_command_message_parser
